/* File: rtl/uhecr_config_regs.sv */
// Extension configuration registers of the USB 2.0 host controller
`timescale 1ns/1ps

module uhecr_config_regs (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Configuration port of the first full-speed function
  input  wire logic        ocfg_rd,
  input  wire logic        ocfg_wr,
  input  wire logic [7:0]  ocfg_addr,
  input  wire logic [3:0]  ocfg_be,
  input  wire logic [31:0] ocfg_wdata,
  output logic [31:0]      ocfg_rdata,
  output logic             ocfg_ack,
  // Configuration port of the high-speed function
  input  wire logic        ecfg_rd,
  input  wire logic        ecfg_wr,
  input  wire logic [7:0]  ecfg_addr,
  input  wire logic [3:0]  ecfg_be,
  input  wire logic [31:0] ecfg_wdata,
  output logic [31:0]      ecfg_rdata,
  output logic             ecfg_ack,
  // Serial ROM preload
  input  wire logic        rom_load,
  input  wire logic [31:0] rom_data,
  // Legacy enable pin and power state
  input  wire logic        legacy_en_pin,
  input  wire logic [1:0]  power_state,
  // Controls to the rest of the controller
  output logic [4:0]       port_active,
  output logic             kbd_trap_direct,
  output logic             kbd_trap_pci_io,
  output logic             subsys_id_write_unlock,
  output logic             port_power_ctl_cap,
  output logic             ehci_disable,
  output logic             ehci_mem_enable,
  output logic             clock_sel_48mhz,
  output logic             global_suspend
);

  logic [31:0] port_legacy_config_r;
  logic [31:0] controller_clock_config_r;
  logic        cfg_seen_r;
  logic        legacy_meta_r;
  logic        legacy_sync_r;
  logic [31:0] ocfg_rdata_r;
  logic        ocfg_ack_r;
  logic [31:0] ecfg_rdata_r;
  logic        ecfg_ack_r;
  logic [4:0]  port_active_r;
  logic        kbd_trap_direct_r;
  logic        kbd_trap_pci_io_r;
  logic        subsys_id_write_unlock_r;
  logic        port_power_ctl_cap_r;
  logic        ehci_disable_r;
  logic        ehci_mem_enable_r;
  logic        clock_sel_48mhz_r;
  logic        global_suspend_r;

  logic        o_hit_plc;
  logic        o_hit_ccc;
  logic        e_hit_plc;
  logic        e_hit_ccc;
  logic        e_live;
  logic [31:0] port_legacy_config_nxt;
  logic [31:0] controller_clock_config_nxt;
  logic [2:0]  port_cnt;

  // Byte-enable merge limited to the writable bits
  function automatic logic [31:0] uhecr_merge(input logic [31:0] cur,
                                              input logic [31:0] wdata,
                                              input logic [3:0]  be,
                                              input logic [31:0] wmask);
    logic [31:0] lanes;
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
    return (cur & ~lanes) | (wdata & lanes);
  endfunction : uhecr_merge

  // Address decode for both configuration paths
  always_comb begin
    o_hit_plc  = (ocfg_addr[7:2] == uhecr_pkg::PORT_LEGACY_CONFIG_OFS[7:2]);
    o_hit_ccc  = (ocfg_addr[7:2] == uhecr_pkg::CONTROLLER_CLOCK_CONFIG_OFS[7:2]);
    e_hit_plc  = (ecfg_addr[7:2] == uhecr_pkg::PORT_LEGACY_CONFIG_OFS[7:2]);
    e_hit_ccc  = (ecfg_addr[7:2] == uhecr_pkg::CONTROLLER_CLOCK_CONFIG_OFS[7:2]);
    e_live     = ~controller_clock_config_r[uhecr_pkg::HS_DISABLE_BIT];
  end

  // Next register values; high-speed path first, so the other path wins on overlap
  always_comb begin
    port_legacy_config_nxt      = port_legacy_config_r;
    controller_clock_config_nxt = controller_clock_config_r;
    // High-speed writes are dropped while that function is disabled
    if (ecfg_wr && e_live && e_hit_plc) begin
      port_legacy_config_nxt = uhecr_merge(port_legacy_config_nxt, ecfg_wdata, ecfg_be,
                                           uhecr_pkg::PORT_LEGACY_WR_MASK);
    end
    if (ecfg_wr && e_live && e_hit_ccc) begin
      controller_clock_config_nxt = uhecr_merge(controller_clock_config_nxt, ecfg_wdata,
                                                ecfg_be, uhecr_pkg::CLOCK_CFG_EHCI_MASK);
    end
    if (ocfg_wr && o_hit_plc) begin
      port_legacy_config_nxt = uhecr_merge(port_legacy_config_nxt, ocfg_wdata, ocfg_be,
                                           uhecr_pkg::PORT_LEGACY_WR_MASK);
    end
    if (ocfg_wr && o_hit_ccc) begin
      controller_clock_config_nxt = uhecr_merge(controller_clock_config_nxt, ocfg_wdata,
                                                ocfg_be, uhecr_pkg::CLOCK_CFG_WR_MASK);
    end
    // A preload overrides same-cycle writes to the first register
    if (rom_load && !cfg_seen_r) begin
      port_legacy_config_nxt = (rom_data & uhecr_pkg::ROM_LOAD_MASK)
                             | (port_legacy_config_r & ~uhecr_pkg::ROM_LOAD_MASK);
    end
  end

  // Marks the first configuration access; ROM preload closes then
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cfg_seen_r <= 1'b0;
    end else if (ocfg_rd || ocfg_wr || ((ecfg_rd || ecfg_wr) && e_live)) begin
      cfg_seen_r <= 1'b1;
    end
  end

  // Shared first register, one copy for both paths
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      port_legacy_config_r <= uhecr_pkg::PORT_LEGACY_CONFIG_RST;
    end else begin
      port_legacy_config_r <= port_legacy_config_nxt;
    end
  end

  // Second register
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      controller_clock_config_r <= uhecr_pkg::CONTROLLER_CLOCK_CONFIG_RST;
    end else begin
      controller_clock_config_r <= controller_clock_config_nxt;
    end
  end

  // Read path of the full-speed function; unmapped offsets read zero
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ocfg_rdata_r <= 32'h0000_0000;
      ocfg_ack_r   <= 1'b0;
    end else begin
      ocfg_ack_r <= ocfg_rd || ocfg_wr;
      // Writes and misses return zero, so no stale word lingers
      if (ocfg_rd && o_hit_plc) begin
        ocfg_rdata_r <= port_legacy_config_r;
      end else if (ocfg_rd && o_hit_ccc) begin
        ocfg_rdata_r <= controller_clock_config_r;
      end else begin
        ocfg_rdata_r <= 32'h0000_0000;
      end
    end
  end

  // Read path of the high-speed function; silent while it is disabled
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ecfg_rdata_r <= 32'h0000_0000;
      ecfg_ack_r   <= 1'b0;
    end else begin
      ecfg_ack_r <= (ecfg_rd || ecfg_wr) && e_live;
      if (ecfg_rd && e_live && e_hit_plc) begin
        ecfg_rdata_r <= port_legacy_config_r;
      end else if (ecfg_rd && e_live && e_hit_ccc) begin
        ecfg_rdata_r <= controller_clock_config_r & uhecr_pkg::CLOCK_CFG_EHCI_MASK;
      end else begin
        ecfg_rdata_r <= 32'h0000_0000;
      end
    end
  end

  // Legacy enable pin synchroniser
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      legacy_meta_r <= 1'b0;
      legacy_sync_r <= 1'b0;
    end else begin
      // Only the second stage is read by the trap logic
      legacy_meta_r <= legacy_en_pin;
      legacy_sync_r <= legacy_meta_r;
    end
  end

  // Active port mask from the port count field
  always_comb begin
    port_cnt = port_legacy_config_r[uhecr_pkg::PORT_CNT_MSB:uhecr_pkg::PORT_CNT_LSB];
  end

  // Registered active-port mask
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      port_active_r <= uhecr_pkg::PORTS_MASK5;
    end else begin
      case (port_cnt)
        uhecr_pkg::PORT_CNT_4: port_active_r <= uhecr_pkg::PORTS_MASK4;
        uhecr_pkg::PORT_CNT_3: port_active_r <= uhecr_pkg::PORTS_MASK3;
        uhecr_pkg::PORT_CNT_2: port_active_r <= uhecr_pkg::PORTS_MASK2;
        default:               port_active_r <= uhecr_pkg::PORTS_MASK5; // Illegal codes: five
      endcase
    end
  end

  // Keyboard port interception mode, gated by the legacy pin
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      kbd_trap_direct_r <= 1'b0;
      kbd_trap_pci_io_r <= 1'b0;
    end else begin
      kbd_trap_direct_r <= legacy_sync_r
                         & ~port_legacy_config_r[uhecr_pkg::LEGACY_DECODE_BIT];
      kbd_trap_pci_io_r <= legacy_sync_r
                         & port_legacy_config_r[uhecr_pkg::LEGACY_DECODE_BIT];
    end
  end

  // Subsystem ID write unlock
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      subsys_id_write_unlock_r <= 1'b0;
    end else begin
      subsys_id_write_unlock_r <= port_legacy_config_r[uhecr_pkg::ID_UNLOCK_BIT];
    end
  end

  // Port power switch capability for the structural parameter register
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      port_power_ctl_cap_r <= 1'b1;
    end else begin
      port_power_ctl_cap_r <= port_legacy_config_r[uhecr_pkg::PWR_SWITCH_BIT];
    end
  end

  // System clock source select
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      clock_sel_48mhz_r <= 1'b0;
    end else begin
      clock_sel_48mhz_r <= controller_clock_config_r[uhecr_pkg::CLOCK_SEL_BIT];
    end
  end

  // High-speed function enable
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ehci_disable_r    <= 1'b0;
      ehci_mem_enable_r <= 1'b1;
    end else begin
      ehci_disable_r    <= controller_clock_config_r[uhecr_pkg::HS_DISABLE_BIT];
      ehci_mem_enable_r <= ~controller_clock_config_r[uhecr_pkg::HS_DISABLE_BIT];
    end
  end

  // Global suspend outside the fully powered state
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      global_suspend_r <= 1'b0;
    end else begin
      global_suspend_r <= (power_state != uhecr_pkg::PWR_STATE_D0);
    end
  end

  // Outputs straight from flip-flops
  assign ocfg_rdata             = ocfg_rdata_r;
  assign ocfg_ack               = ocfg_ack_r;
  assign ecfg_rdata             = ecfg_rdata_r;
  assign ecfg_ack               = ecfg_ack_r;
  assign port_active            = port_active_r;
  assign kbd_trap_direct        = kbd_trap_direct_r;
  assign kbd_trap_pci_io        = kbd_trap_pci_io_r;
  assign subsys_id_write_unlock = subsys_id_write_unlock_r;
  assign port_power_ctl_cap     = port_power_ctl_cap_r;
  assign ehci_disable           = ehci_disable_r;
  assign ehci_mem_enable        = ehci_mem_enable_r;
  assign clock_sel_48mhz        = clock_sel_48mhz_r;
  assign global_suspend         = global_suspend_r;

endmodule : uhecr_config_regs

/* File: rtl/uhecr_pkg.sv */
// Constants for the host controller extension configuration registers
package uhecr_pkg;

  // Register byte offsets in configuration space
  localparam logic [7:0]  PORT_LEGACY_CONFIG_OFS      = 8'hE0;
  localparam logic [7:0]  CONTROLLER_CLOCK_CONFIG_OFS = 8'hE4;

  // Reset values
  localparam logic [31:0] PORT_LEGACY_CONFIG_RST      = 32'h6CB0_3305;
  localparam logic [31:0] CONTROLLER_CLOCK_CONFIG_RST = 32'h0000_0000;

  // Bits that software or the serial ROM may change
  localparam logic [31:0] PORT_LEGACY_WR_MASK         = 32'hFF7F_FFFF;
  localparam logic [31:0] CLOCK_CFG_WR_MASK           = 32'h0000_007F;
  localparam logic [31:0] ROM_LOAD_MASK               = 32'hFF7F_FF7F;
  // Bits of the clock register that the high-speed function may read and write
  localparam logic [31:0] CLOCK_CFG_EHCI_MASK         = 32'h0000_007E;

  // Field positions in port_legacy_config
  localparam int PORT_CNT_LSB      = 0;
  localparam int PORT_CNT_MSB      = 2;
  localparam int LEGACY_DECODE_BIT = 3;
  localparam int ID_UNLOCK_BIT     = 7;
  localparam int PWR_SWITCH_BIT    = 21;

  // Field positions in controller_clock_config
  localparam int HS_DISABLE_BIT    = 0;
  localparam int CLOCK_SEL_BIT     = 5;

  // Port count encodings and active-port masks
  localparam int          NUM_PORTS   = 5;
  localparam logic [2:0]  PORT_CNT_5  = 3'h5;
  localparam logic [2:0]  PORT_CNT_4  = 3'h4;
  localparam logic [2:0]  PORT_CNT_3  = 3'h3;
  localparam logic [2:0]  PORT_CNT_2  = 3'h2;
  localparam logic [4:0]  PORTS_MASK5 = 5'h1F;
  localparam logic [4:0]  PORTS_MASK4 = 5'h0F;
  localparam logic [4:0]  PORTS_MASK3 = 5'h07;
  localparam logic [4:0]  PORTS_MASK2 = 5'h03;

  // Power state encoding
  localparam logic [1:0]  PWR_STATE_D0 = 2'h0;

endpackage : uhecr_pkg

/* File: tb/uhecr_config_regs_props.sv */
// Checker for the host controller extension configuration registers
`timescale 1ns/1ps
module uhecr_config_regs_props (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rstn,
  // Configuration paths
  input wire logic        ocfg_rd,
  input wire logic        ocfg_wr,
  input wire logic [7:0]  ocfg_addr,
  input wire logic [31:0] ocfg_rdata,
  input wire logic        ocfg_ack,
  input wire logic        ecfg_rd,
  input wire logic        ecfg_wr,
  input wire logic [7:0]  ecfg_addr,
  input wire logic [31:0] ecfg_rdata,
  input wire logic        ecfg_ack,
  // Pins and controls
  input wire logic        rom_load,
  input wire logic        legacy_en_pin,
  input wire logic [1:0]  power_state,
  input wire logic [4:0]  port_active,
  input wire logic        kbd_trap_direct,
  input wire logic        kbd_trap_pci_io,
  input wire logic        subsys_id_write_unlock,
  input wire logic        port_power_ctl_cap,
  input wire logic        ehci_disable,
  input wire logic        ehci_mem_enable,
  input wire logic        clock_sel_48mhz,
  input wire logic        global_suspend
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // Active-port mask for a port count, unknown codes act as five ports
  function automatic logic [4:0] pm(input logic [2:0] c);
    return c == 3'h4 ? 5'h0F : c == 3'h3 ? 5'h07 : c == 3'h2 ? 5'h03 : 5'h1F;
  endfunction : pm

  a_ocfg_ack_pulse: assert property (ocfg_ack == $past(ocfg_rd || ocfg_wr))
    else $error("ocfg ack not one cycle after request");
  a_ehci_ack_gate: assert property ((ecfg_rd || ecfg_wr) |=> ecfg_ack != ehci_disable)
    else $error("ecfg ack disagrees with disable bit");
  a_ehci_refused_zero: assert property ((ecfg_rd || ecfg_wr) |=> ecfg_ack || ecfg_rdata == 32'h0)
    else $error("refused ecfg access returned data");
  a_mem_en_inverse: assert property (ehci_mem_enable != ehci_disable)
    else $error("memory enable not inverse of disable");
  a_suspend_state: assert property (global_suspend == ($past(power_state) != 2'h0))
    else $error("suspend flag wrong for power state");
  a_e4_hides_bit0: assert property (ecfg_rd && ecfg_addr == 8'hE4 ##1 ecfg_ack |-> !ecfg_rdata[0])
    else $error("disable bit visible through ecfg");
  a_e4_read_fields: assert property (ocfg_rd && ocfg_addr == 8'hE4 |=>
    ocfg_rdata[0] == ehci_disable && ocfg_rdata[5] == clock_sel_48mhz && ocfg_rdata[31:7] == 25'h0)
    else $error("clock register read disagrees with outputs");
  a_e0_read_fields: assert property (ocfg_rd && ocfg_addr == 8'hE0 |=> ocfg_rdata[23] &&
    ocfg_rdata[7] == subsys_id_write_unlock && ocfg_rdata[21] == port_power_ctl_cap)
    else $error("port register read disagrees with outputs");
  a_port_count_mask: assert property (ocfg_rd && ocfg_addr == 8'hE0 |=>
    port_active == pm(ocfg_rdata[2:0]))
    else $error("active ports disagree with count");
  a_legacy_pin_off: assert property (!legacy_en_pin [*4] |=> !kbd_trap_direct && !kbd_trap_pci_io)
    else $error("keyboard trap active with legacy pin low");
  a_trap_exclusive: assert property (!(kbd_trap_direct && kbd_trap_pci_io))
    else $error("both keyboard trap modes active");

  // Main scenarios reached
  c_ehci_refused: cover property ((ecfg_rd || ecfg_wr) ##1 ehci_disable);
  c_rom_load: cover property (rom_load);
  c_suspend: cover property ($rose(global_suspend));
endmodule : uhecr_config_regs_props

bind uhecr_config_regs uhecr_config_regs_props uhecr_config_regs_props_i (
  .core_clk               (core_clk),
  .rstn                   (rstn),
  .ocfg_rd                (ocfg_rd),
  .ocfg_wr                (ocfg_wr),
  .ocfg_addr              (ocfg_addr),
  .ocfg_rdata             (ocfg_rdata),
  .ocfg_ack               (ocfg_ack),
  .ecfg_rd                (ecfg_rd),
  .ecfg_wr                (ecfg_wr),
  .ecfg_addr              (ecfg_addr),
  .ecfg_rdata             (ecfg_rdata),
  .ecfg_ack               (ecfg_ack),
  .rom_load               (rom_load),
  .legacy_en_pin          (legacy_en_pin),
  .power_state            (power_state),
  .port_active            (port_active),
  .kbd_trap_direct        (kbd_trap_direct),
  .kbd_trap_pci_io        (kbd_trap_pci_io),
  .subsys_id_write_unlock (subsys_id_write_unlock),
  .port_power_ctl_cap     (port_power_ctl_cap),
  .ehci_disable           (ehci_disable),
  .ehci_mem_enable        (ehci_mem_enable),
  .clock_sel_48mhz        (clock_sel_48mhz),
  .global_suspend         (global_suspend)
);

/* File: tb/uhecr_config_regs_tb.sv */
// Self-checking bench for the host controller extension configuration registers
`timescale 1ns/1ps
module uhecr_config_regs_tb;
  logic        core_clk = 0, rstn = 0, ocfg_rd = 0, ocfg_wr = 0, ocfg_ack;
  logic        ecfg_rd = 0, ecfg_wr = 0, ecfg_ack, rom_load = 0, legacy_en_pin = 0;
  logic [7:0]  ocfg_addr = 8'h00, ecfg_addr = 8'h00;
  logic [3:0]  ocfg_be = 4'h0, ecfg_be = 4'h0;
  logic [31:0] ocfg_wdata = 32'h0, ecfg_wdata = 32'h0, ocfg_rdata, ecfg_rdata;
  logic [31:0] rom_data = 32'h0, s = 32'h17, e0, e4;
  logic [1:0]  power_state = 2'h0;
  logic [4:0]  port_active;
  logic        kbd_trap_direct, kbd_trap_pci_io, subsys_id_write_unlock, port_power_ctl_cap;
  logic        ehci_disable, ehci_mem_enable, clock_sel_48mhz, global_suspend;
  int          error_cnt = 0, tests_run = 0, i;

  // 40 MHz clock
  always #12.5 core_clk = ~core_clk;

  uhecr_config_regs uhecr_config_regs_i (
    .core_clk               (core_clk),
    .rstn                   (rstn),
    .ocfg_rd                (ocfg_rd),
    .ocfg_wr                (ocfg_wr),
    .ocfg_addr              (ocfg_addr),
    .ocfg_be                (ocfg_be),
    .ocfg_wdata             (ocfg_wdata),
    .ocfg_rdata             (ocfg_rdata),
    .ocfg_ack               (ocfg_ack),
    .ecfg_rd                (ecfg_rd),
    .ecfg_wr                (ecfg_wr),
    .ecfg_addr              (ecfg_addr),
    .ecfg_be                (ecfg_be),
    .ecfg_wdata             (ecfg_wdata),
    .ecfg_rdata             (ecfg_rdata),
    .ecfg_ack               (ecfg_ack),
    .rom_load               (rom_load),
    .rom_data               (rom_data),
    .legacy_en_pin          (legacy_en_pin),
    .power_state            (power_state),
    .port_active            (port_active),
    .kbd_trap_direct        (kbd_trap_direct),
    .kbd_trap_pci_io        (kbd_trap_pci_io),
    .subsys_id_write_unlock (subsys_id_write_unlock),
    .port_power_ctl_cap     (port_power_ctl_cap),
    .ehci_disable           (ehci_disable),
    .ehci_mem_enable        (ehci_mem_enable),
    .clock_sel_48mhz        (clock_sel_48mhz),
    .global_suspend         (global_suspend)
  );

  // Pseudo-random step
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  // Port register image with private fields at their defaults except bit 23, and a legal count
  function automatic logic [31:0] img(input logic [31:0] v);
    return (v & 32'h0020_0088) | 32'h6C10_3300 | {29'h0, 3'h2 + {1'b0, v[1:0]}};
  endfunction : img
  // Active-port mask for a port count
  function automatic logic [4:0] pmask(input logic [2:0] c);
    return c == 3'h4 ? 5'h0F : c == 3'h3 ? 5'h07 : c == 3'h2 ? 5'h03 : 5'h1F;
  endfunction : pmask
  // Byte-lane merge limited to writable bits
  function automatic logic [31:0] mrg(input logic [31:0] o, d, m, input logic [3:0] b);
    logic [31:0] k;
    k = m & {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
    return (d & k) | (o & ~k);
  endfunction : mrg

  task automatic chk(input string n, input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, exp, got);
    end
  endtask : chk

  task automatic conclude();
    if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude

  // Reset for five cycles and reload the model
  task automatic rst();
    rstn <= 0;
    legacy_en_pin <= 0;
    power_state <= 2'h0;
    repeat (5) @(posedge core_clk);
    rstn <= 1;
    e0 = uhecr_pkg::PORT_LEGACY_CONFIG_RST;
    e4 = uhecr_pkg::CONTROLLER_CLOCK_CONFIG_RST;
  endtask : rst

  // One access on either path, compared against the model
  task automatic acc(input bit e, w, input logic [7:0] a, input logic [3:0] b,
                     input logic [31:0] d);
    logic        ok;
    logic [31:0] x;
    ok = !(e && e4[0]);
    x = a == 8'hE0 ? e0 : a == 8'hE4 ? (e ? e4 & 32'hFFFF_FFFE : e4) : 32'h0;
    @(posedge core_clk);
    if (e) begin
      {ecfg_rd, ecfg_wr, ecfg_addr, ecfg_be, ecfg_wdata} <= {!w, w, a, b, d};
    end else begin
      {ocfg_rd, ocfg_wr, ocfg_addr, ocfg_be, ocfg_wdata} <= {!w, w, a, b, d};
    end
    @(posedge core_clk);
    {ocfg_rd, ocfg_wr, ecfg_rd, ecfg_wr} <= 4'h0;
    #1;
    if (ok && w && a == 8'hE0) e0 = mrg(e0, d, uhecr_pkg::PORT_LEGACY_WR_MASK, b);
    if (ok && w && a == 8'hE4) e4 = mrg(e4, d, e ? uhecr_pkg::CLOCK_CFG_EHCI_MASK
                                             : uhecr_pkg::CLOCK_CFG_WR_MASK, b);
    chk("ack", {31'h0, e ? ecfg_ack : ocfg_ack}, {31'h0, ok});
    chk("rdata", e ? ecfg_rdata : ocfg_rdata, ok && !w ? x : 32'h0);
  endtask : acc

  // All control outputs against the model
  task automatic outs();
    chk("port_active", {27'h0, port_active}, {27'h0, pmask(e0[2:0])});
    chk("kbd_trap_direct", {31'h0, kbd_trap_direct}, {31'h0, legacy_en_pin & !e0[3]});
    chk("kbd_trap_pci_io", {31'h0, kbd_trap_pci_io}, {31'h0, legacy_en_pin & e0[3]});
    chk("id_unlock", {31'h0, subsys_id_write_unlock}, {31'h0, e0[7]});
    chk("power_cap", {31'h0, port_power_ctl_cap}, {31'h0, e0[21]});
    chk("ehci_disable", {31'h0, ehci_disable}, {31'h0, e4[0]});
    chk("ehci_mem_enable", {31'h0, ehci_mem_enable}, {31'h0, !e4[0]});
    chk("clock_sel", {31'h0, clock_sel_48mhz}, {31'h0, e4[5]});
    chk("suspend", {31'h0, global_suspend}, {31'h0, power_state != 2'h0});
  endtask : outs

  // Main sequence
  initial begin
    rst();
    @(posedge core_clk);
    #1;
    outs();
    // Serial ROM image is taken only before the first access
    for (i = 0; i < 2; i++) begin
      s = lfsr(s);
      @(posedge core_clk);
      rom_load <= 1;
      rom_data <= img(s);
      @(posedge core_clk);
      rom_load <= 0;
      if (i == 0) e0 = (img(s) & uhecr_pkg::ROM_LOAD_MASK)
                     | (e0 & ~uhecr_pkg::ROM_LOAD_MASK);
      acc(0, 0, 8'hE0, 4'hF, 32'h0);
    end
    outs();
    // Second reset in mid-run, then random traffic on both paths
    @(posedge core_clk);
    rst();
    @(posedge core_clk);
    #1;
    outs();
    for (i = 0; i < 60; i++) begin
      s = lfsr(s);
      @(posedge core_clk);
      legacy_en_pin <= s[8];
      power_state <= s[10:9];
      acc(s[11], 1, s[12] ? 8'hE4 : 8'hE0, s[16:13],
          s[12] ? (s & 32'h21) | 32'hFFFF_FF80 : img(s));
      acc(0, 0, 8'hE0, 4'h0, 32'h0);
      acc(1, 0, 8'hE0, 4'h0, 32'h0);
      acc(0, 0, 8'hE4, 4'h0, 32'h0);
      acc(1, 0, 8'hE4, 4'h0, 32'h0);
      acc(s[17], 0, 8'h40, 4'h0, 32'h0);
      outs();
    end
    conclude();
  end
endmodule : uhecr_config_regs_tb
